// [sim/interrupt_dispatch_timing_tb.sv]
/*
  self-checking bench for irq_dispatch dispatch, return and mask timing.
  assumes irq_exec_model as processor; tick shortened to 2 cycles.
*/
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin errors++; \
  $display("CHECK FAILED %0t got %0h exp %0h", $time, a, e); end end
module interrupt_dispatch_timing_tb;
  import irq_dispatch_pkg::*;
  localparam int TC = 2;
  logic        MCLK = 0, RESETN = 0, ERR_MASK_REQ = 0, EDIT_MASK_REQ = 0, EDIT_STALL_REQ = 0;
  logic [2:0]  IRQ_REQ = 3'h0, PENDING;
  logic [1:0]  ROUTINE_KIND;
  logic        ROUTINE_RETURN_INSTRUCTION, ROUTINE_CALL, IN_ROUTINE, RESUME, MASKED;
  int          errors = 0, checks = 0, hold = 3, c, k, n;
  logic [31:0] seed = 32'h8B7F9B59;
  int          kind_q[$];
  always #12.5 MCLK = ~MCLK;
  irq_dispatch #(.EDIT_MASK_MAX_US(50), .TICK_CYCLES(TC)) dut_u (.MCLK(MCLK), .RESETN(RESETN),
    .IRQ_REQ(IRQ_REQ), .ERR_MASK_REQ(ERR_MASK_REQ), .EDIT_MASK_REQ(EDIT_MASK_REQ),
    .EDIT_STALL_REQ(EDIT_STALL_REQ), .ROUTINE_RETURN_INSTRUCTION(ROUTINE_RETURN_INSTRUCTION),
    .ROUTINE_CALL(ROUTINE_CALL), .ROUTINE_KIND(ROUTINE_KIND), .IN_ROUTINE(IN_ROUTINE),
    .RESUME(RESUME), .MASKED(MASKED), .PENDING(PENDING));
  irq_exec_model exec_u (.clk(MCLK), .rst_n(RESETN), .in_routine(IN_ROUTINE), .hold(hold),
    .routine_return_instruction(ROUTINE_RETURN_INSTRUCTION));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic results();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wait_hi(ref logic s);
    c = 0;
    do
    begin
      @(posedge MCLK);
      #1;
      c++;
    end
    while (s !== 1'b1 && c < 20000);
    if (c >= 20000)
    begin
      errors++;
      $display("CHECK FAILED %0t timeout", $time);
      results();
    end
  endtask
  // ----------------------------------------
  // one request, optional mask, full return
  // ----------------------------------------
  task automatic shot(input logic [2:0] src, input logic [2:0] msk, input int mus, input int eus);
    @(posedge MCLK);
    IRQ_REQ <= src;
    {ERR_MASK_REQ, EDIT_MASK_REQ, EDIT_STALL_REQ} <= msk;
    fork
      begin
        repeat (110 * TC) @(posedge MCLK);
        #1;
        if (eus > 130) `CHK(PENDING, src)
        repeat (mus * TC - 110 * TC) @(posedge MCLK);
        {ERR_MASK_REQ, EDIT_MASK_REQ, EDIT_STALL_REQ} <= 3'h0;
      end
      wait_hi(ROUTINE_CALL);
    join
    `CHK(c >= eus * TC - 6 && c <= eus * TC + 14, 1'b1)
    k = kind_q.pop_front();
    `CHK(ROUTINE_KIND, 2'(k))
    @(posedge MCLK);
    IRQ_REQ <= 3'h0;
    wait_hi(RESUME);
    `CHK(c >= hold + 30 * TC && c <= hold + 30 * TC + 16, 1'b1)
    `CHK(IN_ROUTINE, 1'b0)
    $display("test src %0h mask %0h done", src, msk);
  endtask
  initial
  begin
    repeat (4) @(posedge MCLK);
    `CHK({ROUTINE_CALL, IN_ROUTINE, RESUME, MASKED, PENDING}, 7'h00)
    RESETN <= 1'b1;
    repeat (8) @(posedge MCLK);
    for (n = 0; n < 3; n++)
    begin
      k = int'(rnd() % 3);
      hold = 2 + int'(rnd() % 40);
      kind_q.push_back(k);
      shot(3'h1 << k, 3'h0, 0, 130);
    end
    for (n = 0; n < 3; n++)
    begin
      kind_q.push_back(0);
      shot(3'h1, 3'h4 >> n, n == 2 ? 150 : 120, n == 2 ? 180 : 130);
    end
    kind_q = {0, 1, 2};
    shot(3'h7, 3'h0, 0, 130);
    repeat (2)
    begin
      wait_hi(ROUTINE_CALL);
      k = kind_q.pop_front();
      `CHK(ROUTINE_KIND, 2'(k))
      wait_hi(RESUME);
    end
    @(posedge MCLK);
    IRQ_REQ <= 3'h2;
    repeat (60 * TC) @(posedge MCLK);
    RESETN <= 1'b0;
    IRQ_REQ <= 3'h0;
    repeat (4) @(posedge MCLK);
    `CHK({ROUTINE_CALL, IN_ROUTINE, RESUME, MASKED, PENDING}, 7'h00)
    RESETN <= 1'b1;
    kind_q.push_back(1);
    shot(3'h2, 3'h0, 0, 130);
    results();
  end
endmodule

// [sim/irq_dispatch_sva.sv]
/*
  port-level timing checker for irq_dispatch.
  assumes it is bound to irq_dispatch and sees only its ports.
*/
`timescale 1ns/1ps
module irq_dispatch_sva
#(
  parameter int TICK_CYCLES       = 40,
  parameter int ERR_MASK_MAX_US   = 100,
  parameter int EDIT_MASK_MAX_US  = 600000,
  parameter int EDIT_STALL_MAX_US = 170
)
(
  input wire logic       MCLK,
  input wire logic       RESETN,
  input wire logic       ERR_MASK_REQ,
  input wire logic       EDIT_MASK_REQ,
  input wire logic       EDIT_STALL_REQ,
  input wire logic       ROUTINE_CALL,
  input wire logic [1:0] ROUTINE_KIND,
  input wire logic       IN_ROUTINE,
  input wire logic       RESUME,
  input wire logic       MASKED
);
  localparam int M1   = ERR_MASK_MAX_US > EDIT_STALL_MAX_US ? ERR_MASK_MAX_US : EDIT_STALL_MAX_US;
  localparam int MLIM = (M1 > EDIT_MASK_MAX_US ? M1 : EDIT_MASK_MAX_US) * TICK_CYCLES + 8;
  int ret_cnt_q;
  int msk_cnt_q;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  // ----------------------------------------
  // cycles since routine end, mask length
  // ----------------------------------------
  always_ff @(posedge MCLK or negedge RESETN)
    if (!RESETN)
    begin
      ret_cnt_q <= 0;
      msk_cnt_q <= 0;
    end
    else
    begin
      ret_cnt_q <= IN_ROUTINE ? 0 : ret_cnt_q + 1;
      msk_cnt_q <= MASKED ? msk_cnt_q + 1 : 0;
    end
  AST_CALL_ONE: assert property (ROUTINE_CALL |=> !ROUTINE_CALL)
    else $error("call pulse too long");
  AST_CALL_ENTER: assert property (ROUTINE_CALL |=> IN_ROUTINE)
    else $error("routine not entered");
  AST_KIND_LEGAL: assert property (ROUTINE_CALL |-> ROUTINE_KIND != 2'h3)
    else $error("bad source kind");
  AST_NO_RESUME_IN: assert property (IN_ROUTINE |-> !RESUME)
    else $error("resume inside routine");
  AST_RESUME_LAT: assert property (RESUME |-> ret_cnt_q >= 29 * TICK_CYCLES && ret_cnt_q <= 31 * TICK_CYCLES + 4)
    else $error("return time wrong");
  AST_MASK_ON: assert property ($rose(EDIT_STALL_REQ) |-> ##[1:8] MASKED)
    else $error("stall not masking");
  AST_MASK_OFF: assert property ((!ERR_MASK_REQ && !EDIT_MASK_REQ && !EDIT_STALL_REQ) [*8] |=> !MASKED)
    else $error("mask without request");
  AST_MASK_CAP: assert property (msk_cnt_q <= MLIM)
    else $error("mask window too long");
endmodule

bind irq_dispatch irq_dispatch_sva #(.TICK_CYCLES(TICK_CYCLES), .ERR_MASK_MAX_US(ERR_MASK_MAX_US),
  .EDIT_MASK_MAX_US(EDIT_MASK_MAX_US), .EDIT_STALL_MAX_US(EDIT_STALL_MAX_US)) sva_u (
  .MCLK(MCLK), .RESETN(RESETN), .ERR_MASK_REQ(ERR_MASK_REQ), .EDIT_MASK_REQ(EDIT_MASK_REQ),
  .EDIT_STALL_REQ(EDIT_STALL_REQ), .ROUTINE_CALL(ROUTINE_CALL), .ROUTINE_KIND(ROUTINE_KIND),
  .IN_ROUTINE(IN_ROUTINE), .RESUME(RESUME), .MASKED(MASKED));

// [sim/irq_exec_model.sv]
/*
  processor side: runs the routine for hold cycles, then raises the return.
  assumes the dispatch block's clock and reset.
*/
`timescale 1ns/1ps
module irq_exec_model
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        in_routine,
  input  wire logic [31:0] hold,
  output logic             routine_return_instruction
);
  int cnt_q;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      cnt_q                      <= 0;
      routine_return_instruction <= 1'b0;
    end
    else if (!in_routine)
    begin
      cnt_q                      <= 0;
      routine_return_instruction <= 1'b0;
    end
    else
    begin
      cnt_q                      <= cnt_q + 1;
      routine_return_instruction <= cnt_q >= int'(hold);
    end
endmodule

// [src/irq_dispatch.sv]
/*
  interrupt dispatch timing: turns interrupt requests from three source
  kinds into a call of the service routine and back, with fixed delays
  and mask windows. assumes requests and mask requests are pin inputs
  from outside the clock domain; routine_return_instruction likewise.
*/
// Contract
// [RQ1] sequence: detect, on delay, mask wait, switch, routine, return phase.
// [RQ2] wait 100 us after request rises, independent of other interrupts.
// [RQ3] switch to service routine takes 30 us after delay and mask wait.
// [RQ4] return to interrupted processing takes 30 us after return instruction.
// [RQ5] input, interval timer and high-speed counter interrupts share one timing.
// [RQ6] requests stay pending during a mask window, released when it ends.
// [RQ7] non-fatal error record or clear masks interrupts at most 100 us.
// [RQ8] running-program edit masks interrupts at most 600 ms.
// [RQ9] edit system stall of dispatch lasts at most 170 us.
// [RQ10] delays counted by a microsecond tick; counters cleared by reset.
`timescale 1ns/1ps
`include "irq_dispatch_defines.svh"

module irq_dispatch
  import irq_dispatch_pkg::*;
#(
  parameter int ON_DELAY_US       = `ON_DELAY_US,
  parameter int SWITCH_US         = `SWITCH_US,
  parameter int RETURN_US         = `RETURN_US,
  parameter int ERR_MASK_MAX_US   = `ERR_MASK_MAX_US,
  parameter int EDIT_MASK_MAX_US  = `EDIT_MASK_MAX_US,
  parameter int EDIT_STALL_MAX_US = `EDIT_STALL_MAX_US,
  parameter int TICK_CYCLES       = `TICK_CYCLES
)
(
  input  wire logic       MCLK,
  input  wire logic       RESETN,
  input  wire logic [2:0] IRQ_REQ,
  input  wire logic       ERR_MASK_REQ,
  input  wire logic       EDIT_MASK_REQ,
  input  wire logic       EDIT_STALL_REQ,
  input  wire logic       ROUTINE_RETURN_INSTRUCTION,
  output logic            ROUTINE_CALL,
  output logic [1:0]      ROUTINE_KIND,
  output logic            IN_ROUTINE,
  output logic            RESUME,
  output logic            MASKED,
  output logic [2:0]      PENDING
);

  // counter widths: 7-bit on delay, 5-bit phases, 20-bit mask windows
  if (ON_DELAY_US < 1 || ON_DELAY_US > 128 || SWITCH_US < 1 || SWITCH_US > 32
      || RETURN_US < 1 || RETURN_US > 32 || ERR_MASK_MAX_US < 1
      || ERR_MASK_MAX_US > 1048575 || EDIT_STALL_MAX_US < 1 || EDIT_STALL_MAX_US > 1048575
      || EDIT_MASK_MAX_US < 1 || EDIT_MASK_MAX_US > 1048575)
  begin : g_bad_param
    $error("irq_dispatch: timing parameter out of range");
  end

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  localparam int NIN = 7;
  logic [NIN-1:0] raw;
  logic [NIN-1:0] s1_q;
  logic [NIN-1:0] s2_q;
  logic [NIN-1:0] s3_q;
  logic [NIN-1:0] flt_q;

  assign raw = {ROUTINE_RETURN_INSTRUCTION, EDIT_STALL_REQ, EDIT_MASK_REQ,
                ERR_MASK_REQ, IRQ_REQ};

  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      flt_q <= '0;
    end
    else
    begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < NIN; i++)
        if (s2_q[i] == s3_q[i])
          flt_q[i] <= s3_q[i];
    end
  end

  logic [NIN-1:0] flt_old_q;
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
      flt_old_q <= '0;
    else
      flt_old_q <= flt_q;
  end

  wire [2:0] irq_rise = flt_q[2:0] & ~flt_old_q[2:0];
  wire       ret_rise = flt_q[6] & ~flt_old_q[6];
  mask_req_t mreq;
  assign mreq = '{err_mask: flt_q[3], edit_mask: flt_q[4], edit_stall: flt_q[5]};

  // ------------------------------------------------------------
  // microsecond time base
  // ------------------------------------------------------------
  logic tick;
  us_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick
  (
    .clk   (MCLK),
    .rst_n (RESETN),
    .tick  (tick)
  );

  // ------------------------------------------------------------
  // per-source on delay, independent of other sources
  // ------------------------------------------------------------
  logic [2:0]  armed_q;
  logic [2:0]  pend_q;
  logic [6:0]  on_cnt_q [3];
  logic [2:0]  taken;

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_src
      wire done = armed_q[g] && tick && (on_cnt_q[g] == 7'(ON_DELAY_US - 1));
      always_ff @(posedge MCLK or negedge RESETN)
      begin
        if (!RESETN)
        begin
          armed_q[g]  <= 1'b0;
          on_cnt_q[g] <= 7'h00;
          pend_q[g]   <= 1'b0;
        end
        else
        begin
          if (irq_rise[g])
          begin
            armed_q[g]  <= 1'b1;                                  // [RQ2]
            on_cnt_q[g] <= 7'h00;
          end
          else if (done)
            armed_q[g] <= 1'b0;
          else if (armed_q[g] && tick)
            on_cnt_q[g] <= on_cnt_q[g] + 7'h01;
          // set wins over the take
          if (done)
            pend_q[g] <= 1'b1;                                    // [RQ5]
          else if (taken[g])
            pend_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // mask windows, each bounded by its own limit
  // ------------------------------------------------------------
  function automatic logic [19:0] bump(input logic act, input logic tk, input logic [19:0] c);
    bump = !act ? 20'h00000 : (tk ? c + 20'h00001 : c);
  endfunction

  logic [19:0] err_cnt_q;
  logic [19:0] edit_cnt_q;
  logic [19:0] stall_cnt_q;
  wire err_open   = mreq.err_mask   && (err_cnt_q   < 20'(ERR_MASK_MAX_US));   // [RQ7]
  wire edit_open  = mreq.edit_mask  && (edit_cnt_q  < 20'(EDIT_MASK_MAX_US));  // [RQ8]
  wire stall_open = mreq.edit_stall && (stall_cnt_q < 20'(EDIT_STALL_MAX_US)); // [RQ9]
  wire mask_open  = err_open | edit_open | stall_open;

  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      err_cnt_q   <= 20'h00000;
      edit_cnt_q  <= 20'h00000;
      stall_cnt_q <= 20'h00000;
    end
    else
    begin
      err_cnt_q   <= bump(mreq.err_mask, tick && err_open, err_cnt_q);
      edit_cnt_q  <= bump(mreq.edit_mask, tick && edit_open, edit_cnt_q);
      stall_cnt_q <= bump(mreq.edit_stall, tick && stall_open, stall_cnt_q);
    end
  end

  // ------------------------------------------------------------
  // dispatch sequence
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_SWITCH, ST_ROUTINE, ST_RETURN} state_t;
  state_t     st_q;
  state_t     st_d;
  logic [4:0] ph_cnt_q;
  src_kind_t  kind_q;

  // fixed priority among simultaneously pending sources
  wire        any_pend = |pend_q;
  src_kind_t  pick;
  assign pick = pend_q[0] ? SRC_INPUT : (pend_q[1] ? SRC_INTERVAL : SRC_HSCOUNT);
  wire        start    = (st_q == ST_IDLE) && any_pend && !mask_open;     // [RQ6]
  wire        sw_done  = (st_q == ST_SWITCH) && tick && (ph_cnt_q == 5'(SWITCH_US - 1));
  wire        rt_done  = (st_q == ST_RETURN) && tick && (ph_cnt_q == 5'(RETURN_US - 1));
  dispatch_t  disp;
  assign disp  = '{grant: start, kind: pick};
  assign taken = start ? (3'b001 << pick) : 3'b000;

  always_comb
  begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE:    if (disp.grant) st_d = ST_SWITCH;               // [RQ1]
      ST_SWITCH:  if (sw_done) st_d = ST_ROUTINE;                 // [RQ3]
      ST_ROUTINE: if (ret_rise) st_d = ST_RETURN;
      ST_RETURN:  if (rt_done) st_d = ST_IDLE;                    // [RQ4]
    endcase
  end

  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      st_q     <= ST_IDLE;
      ph_cnt_q <= 5'h00;
      kind_q   <= SRC_INPUT;
    end
    else
    begin
      st_q <= st_d;
      if (st_d != st_q)
        ph_cnt_q <= 5'h00;
      else if (tick)
        ph_cnt_q <= ph_cnt_q + 5'h01;
      if (disp.grant)
        kind_q <= disp.kind;
    end
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge MCLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      ROUTINE_CALL <= 1'b0;
      ROUTINE_KIND <= 2'h0;
      IN_ROUTINE   <= 1'b0;
      RESUME       <= 1'b0;
      MASKED       <= 1'b0;
      PENDING      <= 3'h0;
    end
    else
    begin
      ROUTINE_CALL <= sw_done;
      ROUTINE_KIND <= kind_q;
      IN_ROUTINE   <= (st_d == ST_ROUTINE);
      RESUME       <= rt_done;
      MASKED       <= mask_open;
      PENDING      <= pend_q;
    end
  end

endmodule

// [src/irq_dispatch_defines.svh]
/*
  timing constants for the interrupt dispatch timing block.
  assumes a 40 MHz system clock; included by bare name.
*/
`ifndef IRQ_DISPATCH_DEFINES_SVH
`define IRQ_DISPATCH_DEFINES_SVH

`define CLK_MHZ            40
`define ON_DELAY_US        100
`define SWITCH_US          30
`define RETURN_US          30
`define ERR_MASK_MAX_US    100
`define EDIT_MASK_MAX_MS   600
`define EDIT_STALL_MAX_US  170
`define TICK_CYCLES        (`CLK_MHZ)
`define EDIT_MASK_MAX_US   (`EDIT_MASK_MAX_MS * 1000)

`endif

// [src/irq_dispatch_pkg.sv]
/*
  types shared by the interrupt dispatch timing block.
  assumes nothing of its surroundings.
*/
package irq_dispatch_pkg;

  typedef enum logic [1:0] {SRC_INPUT, SRC_INTERVAL, SRC_HSCOUNT} src_kind_t;

  typedef struct packed {
    logic err_mask;
    logic edit_mask;
    logic edit_stall;
  } mask_req_t;

  typedef struct packed {
    logic      grant;
    src_kind_t kind;
  } dispatch_t;

endpackage

// [src/us_tick.sv]
/*
  microsecond tick generator: one-cycle pulse every TICK_CYCLES clocks.
  assumes a single system clock and asynchronous active-low reset.
*/
`timescale 1ns/1ps
`include "irq_dispatch_defines.svh"

module us_tick
#(
  parameter int TICK_CYCLES = `TICK_CYCLES
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  output logic      tick
);

  if (TICK_CYCLES < 1 || TICK_CYCLES > 65536)
  begin : g_bad_param
    $error("us_tick: TICK_CYCLES must be 1 to 65536");
  end

  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  wire         wrap = (cnt_q == 16'(TICK_CYCLES - 1));

  assign cnt_d = wrap ? 16'h0000 : cnt_q + 16'h0001;

  // prescaler cleared by reset [RQ10]
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      tick  <= wrap;
    end
  end

endmodule
